// ---- rcpi_ctrl.sv ----
// Control register one with periodic interrupt and clock output logic
// What this block does
// - Eight-bit control register at Eh, cleared when the halt flag sets.
// - Top two bits enable the weekly and daily alarm circuits.
// - Bit five selects 12-hour (zero) or 24-hour (one) counting.
// - 12-hour reads: midnight 12, noon 32, 1 PM 21.
// - Clock output toggles unless both disable bits are one; then high.
// - Select 000 keeps interrupt high; 001 holds it low.
// - Codes 010 and 011 give 2 Hz and 1 Hz square waves.
// - Seconds increment about 92 us after the pulse falling edge.
// - Writing seconds clears the divider and drives the output low in 2 Hz and 1 Hz modes.
// - Level codes fire each second, minute, hour, or month start.
// - In level mode the falling edge meets the seconds increment.
// - Adjustment changes timing every 20 s, low period by up to 3.784 ms.
// - In level mode a one-second period shifts at most 3.784 ms.
// - Flag reads one while output low; writing zero releases level.
// - Halt flag stops all interrupt outputs and starts clock output.
`timescale 1ns/1ps
`default_nettype none
module rcpi_ctrl (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        xtal_in,
    input  wire logic        osc_halt_flag,
    input  wire logic        clkout_disable_a,
    input  wire logic        periodic_flag_clear,
    input  wire logic        sec_write,
    input  wire logic        min_rollover,
    input  wire logic        hour_rollover,
    input  wire logic        month_rollover,
    input  wire logic        adj_active,
    input  wire logic signed [7:0] adj_ticks,
    input  wire logic [5:0]  hour24_bcd,
    input  wire logic        weekly_alarm_match,
    input  wire logic        daily_alarm_match,
    output logic      [5:0]  hour_read,
    output logic             sec_inc,
    output logic             weekly_alarm_enable,
    output logic             daily_alarm_enable,
    output logic             hour_24_mode,
    output logic             test_mode,
    output logic             slow_clock_out,
    output logic             periodic_irq_n,
    output logic             periodic_irq_flag,
    output logic             weekly_alarm_irq_n,
    output logic             daily_alarm_irq_n
);
    import rcpi_pkg::*;

    logic [7:0]         ctrl_ff;
    logic [2:0]         xtal_sync_ff;
    logic               halt_d_ff;
    logic [15:0]        div_ff;
    logic signed [8:0]  ext_ff;
    logic [4:0]         sec20_ff;
    logic               level_low_ff;
    logic               irq_n_ff;
    logic               clk_out_ff;
    logic               week_n_ff;
    logic               day_n_ff;
    logic [5:0]         hour_ff;
    logic               sec_inc_ff;
    logic [7:0]         rdata_ff;
    logic               tick;
    logic               halt_rise;
    logic               rollover;
    logic               inc_event;
    logic               level_event;
    logic [2:0]         sel;
    logic signed [8:0]  nxt_ext;
    logic               nxt_irq_n;

    // Low phase of the pulse waveforms, lengthened or shortened by the adjustment
    function automatic logic pulse_low(input logic [15:0] d,
                                       input logic two_hz,
                                       input logic signed [8:0] ext);
        int di;
        di = int'(d);
        if (two_hz) begin
            pulse_low = (di < int'(DIV_QUARTER)) ||
                ((di >= int'(DIV_HALF)) &&
                 (di < int'(DIV_HALF) + int'(DIV_QUARTER) + int'(ext)));
        end else begin
            pulse_low = di < int'(DIV_HALF) + int'(ext);
        end
    endfunction : pulse_low

    // 24-hour BCD to 12-hour BCD with PM bit
    function automatic logic [5:0] to_12h(input logic [5:0] h);
        int v;
        v = int'(h[5:4]) * 10 + int'(h[3:0]);
        if (v == 0) begin
            to_12h = HOUR_AM12;
        end else if (v < 12) begin
            to_12h = h;
        end else if (v == 12) begin
            to_12h = HOUR_PM12;
        end else if (v < 22) begin
            to_12h = HOUR_PM_BIT | 6'(v - 12);
        end else begin
            to_12h = HOUR_PM_BIT | 6'h10 | 6'(v - 22);
        end
    endfunction : to_12h

    assign sel       = ctrl_ff[SEL_MSB:0];
    assign tick      = xtal_sync_ff[1] & ~xtal_sync_ff[2];
    assign halt_rise = osc_halt_flag & ~halt_d_ff;
    assign rollover  = tick && (int'(div_ff) >= int'(DIV_TERM) + int'(ext_ff));
    assign inc_event = tick && (div_ff == SEC_INC_POS);

    // Level-mode interrupt sources
    always_comb begin
        case (sel)
            SEL_SEC:   level_event = inc_event;
            SEL_MIN:   level_event = inc_event & min_rollover;
            SEL_HOUR:  level_event = inc_event & hour_rollover;
            SEL_MONTH: level_event = inc_event & month_rollover;
            default:   level_event = 1'b0;
        endcase
    end

    // Adjustment chosen on the last second of each 20 s span, applied to the next second
    always_comb begin
        nxt_ext = 9'sd0;
        if (adj_active && sec20_ff == ADJ_PERIOD_LAST) begin
            if (int'(adj_ticks) > ADJ_MAX_TICKS) begin
                nxt_ext = -9'(ADJ_MAX_TICKS);
            end else if (int'(adj_ticks) < -ADJ_MAX_TICKS) begin
                nxt_ext = 9'(ADJ_MAX_TICKS);
            end else begin
                nxt_ext = -9'(adj_ticks);
            end
        end
    end

    always_comb begin
        case (sel)
            SEL_OFF: nxt_irq_n = 1'b1;
            SEL_LOW: nxt_irq_n = 1'b0;
            SEL_2HZ: nxt_irq_n = ~pulse_low(div_ff, 1'b1, ext_ff);
            SEL_1HZ: nxt_irq_n = ~pulse_low(div_ff, 1'b0, ext_ff);
            default: nxt_irq_n = ~level_low_ff;
        endcase
        if (osc_halt_flag) begin
            nxt_irq_n = 1'b1;
        end
    end

    // Crystal sampling
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            xtal_sync_ff <= 3'h0;
            halt_d_ff    <= 1'b0;
        end else begin
            xtal_sync_ff <= {xtal_sync_ff[1:0], xtal_in};
            halt_d_ff    <= osc_halt_flag;
        end
    end

    // Control register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= CTRL_RESET;
        end else if (halt_rise) begin
            ctrl_ff <= CTRL_RESET;
        end else if (reg_wr && reg_addr == CTRL_ADDR) begin
            ctrl_ff <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_addr == CTRL_ADDR) begin
            rdata_ff <= ctrl_ff;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // Sub-second divider on the crystal ticks
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff   <= 16'h0000;
            ext_ff   <= 9'sd0;
            sec20_ff <= 5'h00;
        end else if (sec_write) begin
            div_ff <= 16'h0000;
        end else if (rollover) begin
            div_ff   <= 16'h0000;
            ext_ff   <= nxt_ext;
            sec20_ff <= (sec20_ff == ADJ_PERIOD_LAST) ? 5'h00 : sec20_ff + 5'h01;
        end else if (tick) begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_inc_ff <= 1'b0;
        end else begin
            sec_inc_ff <= inc_event;
        end
    end

    // Level latch, a new event beats a host clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            level_low_ff <= 1'b0;
        end else if (!sel[SEL_MSB] || osc_halt_flag) begin
            level_low_ff <= 1'b0;
        end else if (level_event) begin
            level_low_ff <= 1'b1;
        end else if (periodic_flag_clear) begin
            level_low_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= nxt_irq_n;
        end
    end

    // Clock output and alarm gating
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clk_out_ff <= 1'b1;
            week_n_ff  <= 1'b1;
            day_n_ff   <= 1'b1;
        end else begin
            clk_out_ff <= (ctrl_ff[CLKDIS_B_BIT] & clkout_disable_a) |
                          xtal_sync_ff[1];
            week_n_ff  <= ~(weekly_alarm_match & ctrl_ff[WEEKLY_EN_BIT] &
                            ~osc_halt_flag);
            day_n_ff   <= ~(daily_alarm_match & ctrl_ff[DAILY_EN_BIT] &
                            ~osc_halt_flag);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hour_ff <= 6'h00;
        end else if (ctrl_ff[HOUR_24_BIT]) begin
            hour_ff <= hour24_bcd;
        end else begin
            hour_ff <= to_12h(hour24_bcd);
        end
    end

    assign reg_rdata           = rdata_ff;
    assign hour_read           = hour_ff;
    assign sec_inc             = sec_inc_ff;
    assign weekly_alarm_enable = ctrl_ff[WEEKLY_EN_BIT];
    assign daily_alarm_enable  = ctrl_ff[DAILY_EN_BIT];
    assign hour_24_mode        = ctrl_ff[HOUR_24_BIT];
    assign test_mode           = ctrl_ff[TEST_BIT];
    assign slow_clock_out      = clk_out_ff;
    assign periodic_irq_n      = irq_n_ff;
    assign periodic_irq_flag   = ~irq_n_ff;
    assign weekly_alarm_irq_n  = week_n_ff;
    assign daily_alarm_irq_n   = day_n_ff;

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_sec_write_pulse;
        sec_write && (sel == SEL_2HZ || sel == SEL_1HZ) && !osc_halt_flag;
    endsequence
    sequence s_mode_held;
        ##1 ((sel == SEL_2HZ || sel == SEL_1HZ) && !osc_halt_flag &&
             !sec_write) [*2];
    endsequence

    property p_halt_clear;
        halt_rise |=> ctrl_ff == CTRL_RESET;
    endproperty
    a_halt_clear: assert property (p_halt_clear)
        else $error("control not cleared on halt");

    property p_write;
        reg_wr && reg_addr == CTRL_ADDR && !halt_rise |=>
            ctrl_ff == $past(reg_wdata) ##1 reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_write: assert property (p_write)
        else $error("control write not stored");

    property p_off;
        $past(sel) == SEL_OFF |-> periodic_irq_n;
    endproperty
    a_off: assert property (p_off)
        else $error("irq not off");

    property p_fixed_low;
        $past(sel) == SEL_LOW && !$past(osc_halt_flag) |-> !periodic_irq_n;
    endproperty
    a_fixed_low: assert property (p_fixed_low)
        else $error("irq not held low");

    property p_sec_write;
        s_sec_write_pulse ##0 s_mode_held |-> !periodic_irq_n;
    endproperty
    a_sec_write: assert property (p_sec_write)
        else $error("seconds write did not drive irq low");

    property p_clkout;
        ctrl_ff[CLKDIS_B_BIT] && clkout_disable_a |=> slow_clock_out;
    endproperty
    a_clkout: assert property (p_clkout)
        else $error("clock output not held high");

    property p_level_set;
        level_event && !osc_halt_flag |=> ##1 !periodic_irq_n;
    endproperty
    a_level_set: assert property (p_level_set)
        else $error("level irq missed increment");

    property p_alarm_gate;
        !ctrl_ff[WEEKLY_EN_BIT] |=> weekly_alarm_irq_n;
    endproperty
    a_alarm_gate: assert property (p_alarm_gate)
        else $error("weekly irq while disabled");

    property p_noon;
        !ctrl_ff[HOUR_24_BIT] && hour24_bcd == 6'h12 |=> hour_read == HOUR_PM12;
    endproperty
    a_noon: assert property (p_noon)
        else $error("noon not encoded as PM12");

    property p_halt_irq;
        osc_halt_flag |=> periodic_irq_n && weekly_alarm_irq_n
            && daily_alarm_irq_n;
    endproperty
    a_halt_irq: assert property (p_halt_irq)
        else $error("irq active during halt");
endmodule : rcpi_ctrl
`default_nettype wire

// ---- rcpi_pkg.sv ----
// Constants for the control register and periodic interrupt generator
`default_nettype none
package rcpi_pkg;
    // Register map
    localparam logic [3:0]  CTRL_ADDR      = 4'he;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    // Field positions
    localparam int          WEEKLY_EN_BIT  = 7;
    localparam int          DAILY_EN_BIT   = 6;
    localparam int          HOUR_24_BIT    = 5;
    localparam int          CLKDIS_B_BIT   = 4;
    localparam int          TEST_BIT       = 3;
    localparam int          SEL_MSB        = 2;
    // Periodic select codes
    localparam logic [2:0]  SEL_OFF        = 3'h0;
    localparam logic [2:0]  SEL_LOW        = 3'h1;
    localparam logic [2:0]  SEL_2HZ        = 3'h2;
    localparam logic [2:0]  SEL_1HZ        = 3'h3;
    localparam logic [2:0]  SEL_SEC        = 3'h4;
    localparam logic [2:0]  SEL_MIN        = 3'h5;
    localparam logic [2:0]  SEL_HOUR       = 3'h6;
    localparam logic [2:0]  SEL_MONTH      = 3'h7;
    // Time base
    localparam int          XTAL_HZ        = 32768;
    localparam logic [15:0] DIV_TERM       = 16'h7fff;
    localparam logic [15:0] DIV_HALF       = 16'h4000;
    localparam logic [15:0] DIV_QUARTER    = 16'h2000;
    // Seconds increment lags the pulse falling edge
    localparam int          SEC_INC_DELAY_US = 92;
    localparam int          SEC_INC_TICKS  = SEC_INC_DELAY_US * XTAL_HZ / 1000000;
    localparam logic [15:0] SEC_INC_POS    = 16'(SEC_INC_TICKS - 1);
    // Oscillation adjustment
    localparam int          ADJ_MAX_US     = 3784;
    localparam int          ADJ_MAX_TICKS  =
        (ADJ_MAX_US * XTAL_HZ + 500000) / 1000000;
    localparam logic [4:0]  ADJ_PERIOD_LAST = 5'h13;
    // Hour encoding
    localparam logic [5:0]  HOUR_AM12      = 6'h12;
    localparam logic [5:0]  HOUR_PM12      = 6'h32;
    localparam logic [5:0]  HOUR_PM_BIT    = 6'h20;
endpackage : rcpi_pkg
`default_nettype wire

// ---- rcpi_host.sv ----
// Host model driving the control register port and time writes
`timescale 1ns/1ps
`default_nettype none
module rcpi_host (
    input  wire logic       mclk,
    output logic      [3:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            periodic_flag_clear,
    output logic            sec_write
);
    initial begin
        reg_addr            = 4'h0;
        reg_wr              = 1'b0;
        reg_wdata           = 8'h00;
        periodic_flag_clear = 1'b0;
        sec_write           = 1'b0;
    end
    // Single byte write, address held afterwards for read back
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d & 8'hf7;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr
    // Seconds write, a one-cycle pulse on sec_write that clears the divider
    task automatic sec_wr();
        @(posedge mclk);
        sec_write <= 1'b1;
        @(posedge mclk);
        sec_write <= 1'b0;
    endtask : sec_wr
    task automatic clr_flag();
        @(posedge mclk);
        periodic_flag_clear <= 1'b1;
        @(posedge mclk);
        periodic_flag_clear <= 1'b0;
    endtask : clr_flag
endmodule : rcpi_host
`default_nettype wire

// ---- rcpi_ctrl_periodic_tb_top.sv ----
// Self-checking bench for the control register and periodic interrupt
`timescale 1ns/1ps
`default_nettype none
module rcpi_ctrl_periodic_tb_top;
    import rcpi_pkg::*;
    logic mclk = 0, reset_n = 0, xtal_in = 0, osc_halt_flag = 0;
    logic clkout_disable_a = 0, wk_match = 0, dy_match = 0, min_ro = 0;
    logic [5:0] hour24_bcd = 6'h00;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, obs, d;
    logic reg_wr, flag_clr, sec_write, sec_inc, slow_clk;
    logic irq_n, irq_flag, wk_irq_n, dy_irq_n, wk_en, dy_en, h24, tst;
    logic [5:0] hour_read;
    int err_total = 0, checks_done = 0, i;
    int q_sel[$];
    logic [7:0] q_exp[$];
    event chk_ev;
    always #5 mclk = ~mclk;
    always #50 xtal_in = ~xtal_in;
    rcpi_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .periodic_flag_clear(flag_clr),
        .sec_write(sec_write));
    rcpi_ctrl dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .xtal_in(xtal_in), .osc_halt_flag(osc_halt_flag),
        .clkout_disable_a(clkout_disable_a),
        .periodic_flag_clear(flag_clr), .sec_write(sec_write),
        .min_rollover(min_ro), .hour_rollover(1'b0),
        .month_rollover(1'b0), .adj_active(1'b0), .adj_ticks(8'sh00),
        .hour24_bcd(hour24_bcd), .weekly_alarm_match(wk_match),
        .daily_alarm_match(dy_match), .hour_read(hour_read),
        .sec_inc(sec_inc), .weekly_alarm_enable(wk_en),
        .daily_alarm_enable(dy_en), .hour_24_mode(h24),
        .test_mode(tst), .slow_clock_out(slow_clk),
        .periodic_irq_n(irq_n), .periodic_irq_flag(irq_flag),
        .weekly_alarm_irq_n(wk_irq_n), .daily_alarm_irq_n(dy_irq_n));
    // Note an expectation, then let the monitor compare it
    task automatic chk(input int s, input logic [7:0] e);
        @(negedge mclk);
        q_sel.push_back(s);
        q_exp.push_back(e);
        ->chk_ev;
    endtask : chk
    always @(chk_ev) begin
        case (q_sel[0])
            0: obs = reg_rdata;
            1: obs = {7'h00, irq_n};
            2: obs = {7'h00, irq_flag};
            3: obs = {6'h00, wk_irq_n, dy_irq_n};
            4: obs = {2'h0, hour_read};
            5: obs = {4'h0, wk_en, dy_en, h24, tst};
            default: obs = {7'h00, slow_clk};
        endcase
        checks_done++;
        if (obs !== q_exp[0]) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, obs,
                q_exp[0]);
        end
        void'(q_sel.pop_front());
        void'(q_exp.pop_front());
    end
    task automatic wr_rd(input logic [7:0] v);
        host.wr(CTRL_ADDR, v);
        @(posedge mclk);
    endtask : wr_rd
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #500000;
        err_total++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hc9c0527a));
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        host.wr(CTRL_ADDR, 8'h00);
        chk(0, 8'h00);
        chk(1, 8'h01);
        for (i = 0; i < 6; i++) begin
            d = 8'($urandom) & 8'hf7;
            wr_rd(d);
            chk(0, d);
            chk(5, {d[7:5], 1'b0});
        end
        host.wr(4'h5, 8'hff);
        chk(0, 8'h00);
        host.wr(CTRL_ADDR, 8'hc0);
        wk_match <= 1'b1;
        dy_match <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(3, 8'h00);
        wr_rd(8'h40);
        chk(3, 8'h02);
        wr_rd(8'h00);
        chk(3, 8'h03);
        for (i = 0; i < 24; i++) begin
            @(posedge mclk);
            hour24_bcd <= 6'((i / 10) * 16 + i % 10);
            repeat (3) @(posedge mclk);
            d = (i == 0) ? 8'h12 : (i == 12) ? 8'h32 :
                8'(((i % 12) / 10) * 16 + (i % 12) % 10 + (i > 12) * 32);
            chk(4, d);
        end
        wr_rd(8'h20);
        chk(4, 8'h23);
        @(posedge mclk);
        clkout_disable_a <= 1'b1;
        wr_rd(8'h10);
        for (i = 0; i < 30; i++) chk(6, 8'h01);
        @(posedge mclk);
        clkout_disable_a <= 1'b0;
        // First low cycle seen, so it still stands at the next check
        for (i = 0; i < 100 && slow_clk !== 1'b0; i++) @(negedge mclk);
        chk(6, 8'h00);
        wr_rd(8'h01);
        chk(1, 8'h00);
        chk(2, 8'h01);
        wr_rd(8'h00);
        chk(1, 8'h01);
        host.wr(CTRL_ADDR, 8'h02);
        repeat (2) @(posedge mclk);
        host.sec_wr();
        @(posedge mclk);
        chk(1, 8'h00);
        host.wr(CTRL_ADDR, 8'h04);
        host.sec_wr();
        for (i = 0; i < 300 && sec_inc !== 1'b1; i++) @(negedge mclk);
        @(posedge mclk);
        chk(1, 8'h00);
        chk(2, 8'h01);
        host.clr_flag();
        @(posedge mclk);
        chk(1, 8'h01);
        // Minute code fires only when the increment lands on a rollover
        host.wr(CTRL_ADDR, 8'h05);
        for (int k = 0; k < 2; k++) begin
            min_ro <= k[0];
            host.sec_wr();
            for (i = 0; i < 300 && sec_inc !== 1'b1; i++) @(negedge mclk);
            @(posedge mclk);
            chk(1, {7'h00, ~k[0]});
        end
        host.wr(CTRL_ADDR, 8'hc1);
        @(posedge mclk);
        osc_halt_flag <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(0, 8'h00);
        chk(1, 8'h01);
        chk(3, 8'h03);
        repeat (40) @(posedge mclk);
        end_of_test();
    end
endmodule : rcpi_ctrl_periodic_tb_top
`default_nettype wire
